// [logic/ebla_aligner.sv]
`default_nettype none
module ebla_aligner #(
    parameter int LANES = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic endian_select_pin,
    input wire logic req_valid,
    output logic req_ready,
    input wire ebla_pkg::ebla_req_s req,
    output logic ext_cyc_valid,
    input wire logic ext_cyc_ready,
    output logic [31:0] ext_addr,
    output logic ext_write,
    output logic [31:0] ext_wdata,
    input wire logic [31:0] ext_rdata,
    output logic [3:0] ext_lane_strobe,
    output logic lane3_write_strobe,
    output logic lane2_write_strobe,
    output logic lane1_write_strobe,
    output logic lane0_write_strobe,
    output logic lane3_column_strobe,
    output logic lane2_column_strobe,
    output logic lane1_column_strobe,
    output logic lane0_column_strobe,
    output logic lane3_data_mask,
    output logic lane2_data_mask,
    output logic lane1_data_mask,
    output logic lane0_data_mask,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    output logic order_little
);
    import ebla_pkg::*;

    if (LANES != LANE_COUNT) begin : g_lane_check
        $error("ebla_aligner serves a four-lane data bus only");
    end

    ebla_state_e state_ff, nxt_state;
    ebla_req_s req_ff, nxt_req;
    ebla_beat_s beat_ff, nxt_beat, map;
    logic [1:0] beat_cnt_ff, nxt_beat_cnt;
    logic [31:0] rdata_ff, nxt_rdata;
    logic rsp_ff, nxt_rsp;
    logic order_ff, nxt_order;
    logic [3:0] we_ff, nxt_we;
    logic [3:0] cas_ff, nxt_cas;
    logic [3:0] dqm_ff, nxt_dqm;
    logic busy;

    // Sampled while reset is held, so the last value before release sticks.
    always_comb begin
        nxt_order = srst ? endian_select_pin : order_ff; // RL8
    end

    always_ff @(posedge clk) begin
        order_ff <= nxt_order;
    end

    // The map looks at the next request and beat so that all lane outputs
    // leave flip-flops in the same cycle as the cycle-valid flag.
    ebla_lane_map u_map (
        .order(order_ff),
        .req(nxt_req),
        .beat(nxt_beat_cnt),
        .map(map)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_beat_cnt = beat_cnt_ff;
        nxt_rdata = rdata_ff;
        nxt_rsp = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_req = req;
                    nxt_beat_cnt = BEAT_FIRST;
                    nxt_rdata = '0;
                    nxt_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (ext_cyc_ready) begin
                    for (int l = 0; l < LANE_COUNT; l++) begin
                        if (beat_ff.strobe[l]) begin
                            nxt_rdata[beat_ff.vbyte[l * 2 +: 2] * LANE_BITS +: LANE_BITS] =
                                ext_rdata[l * LANE_BITS +: LANE_BITS]; // RL9
                        end
                    end
                    if (beat_ff.last) begin
                        nxt_state = ST_IDLE;
                        nxt_rsp = 1'b1; // RL9
                    end else begin
                        nxt_beat_cnt = beat_cnt_ff + BEAT_STEP; // RL2 RL6 RL7
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (srst) begin
            nxt_state = ST_IDLE;
            nxt_req = '0;
            nxt_beat_cnt = BEAT_FIRST;
            nxt_rdata = '0;
            nxt_rsp = 1'b0;
        end
    end

    // Lane use is fixed by the map; the memory kind only picks which strobe
    // family carries it. Write strobes stay quiet on reads.
    always_comb begin
        nxt_beat = '0;
        nxt_we = NO_LANES;
        nxt_cas = NO_LANES;
        nxt_dqm = NO_LANES;
        if (nxt_state == ST_BUSY) begin
            nxt_beat = map;
            if (nxt_req.mem == MEM_NORMAL && nxt_req.write) begin
                nxt_we = map.strobe; // RL10
            end else if (nxt_req.mem == MEM_DRAM) begin
                nxt_cas = map.strobe; // RL10
            end else if (nxt_req.mem == MEM_SDRAM) begin
                nxt_dqm = map.strobe; // RL10
            end
        end
    end

    always_ff @(posedge clk) begin
        state_ff <= nxt_state;
        req_ff <= nxt_req;
        beat_cnt_ff <= nxt_beat_cnt;
        beat_ff <= nxt_beat;
        rdata_ff <= nxt_rdata;
        rsp_ff <= nxt_rsp;
        we_ff <= nxt_we;
        cas_ff <= nxt_cas;
        dqm_ff <= nxt_dqm;
    end

    assign busy = (state_ff == ST_BUSY);
    assign req_ready = (state_ff == ST_IDLE);
    assign ext_cyc_valid = busy;
    assign ext_addr = {req_ff.addr[31:2], beat_ff.offset};
    assign ext_write = req_ff.write;
    assign ext_wdata = beat_ff.data;
    assign ext_lane_strobe = beat_ff.strobe;
    assign {lane3_write_strobe, lane2_write_strobe, lane1_write_strobe, lane0_write_strobe} = we_ff;
    assign {lane3_column_strobe, lane2_column_strobe, lane1_column_strobe,
            lane0_column_strobe} = cas_ff;
    assign {lane3_data_mask, lane2_data_mask, lane1_data_mask, lane0_data_mask} = dqm_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rdata_ff;
    assign order_little = order_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic be8, le8, le16, le32;
    assign be8 = busy && order_ff == ORDER_BIG && req_ff.width == SZ_BYTE;
    assign le8 = busy && order_ff == ORDER_LITTLE && req_ff.width == SZ_BYTE;
    assign le16 = busy && order_ff == ORDER_LITTLE && req_ff.width == SZ_WORD;
    assign le32 = busy && order_ff == ORDER_LITTLE && req_ff.width == SZ_LONG;

    a_be8_single_lane: assert property (be8 |-> ext_lane_strobe == 4'h1) // RL1
        else $error("big-endian byte device used a lane other than zero");
    a_be8_long_order: assert property (be8 && req_ff.size == SZ_LONG |-> // RL2
        ext_wdata[7:0] == req_ff.wdata[(3 - beat_cnt_ff) * 8 +: 8])
        else $error("big-endian byte device longword byte order wrong");
    a_le32_byte_lane: assert property (le32 && req_ff.size == SZ_BYTE |-> // RL3
        ext_lane_strobe == (4'h1 << req_ff.addr[1:0]) &&
        ext_wdata[req_ff.addr[1:0] * 8 +: 8] == req_ff.wdata[7:0])
        else $error("little-endian long device byte lane wrong");
    a_le32_word_lanes: assert property (le32 && req_ff.size == SZ_WORD |-> // RL4
        ext_lane_strobe == (req_ff.addr[1] ? 4'hc : 4'h3))
        else $error("little-endian long device word lanes wrong");
    a_le32_long_lanes: assert property (le32 && req_ff.size == SZ_LONG |-> // RL4
        ext_lane_strobe == 4'hf && ext_wdata == req_ff.wdata)
        else $error("little-endian long device longword lanes wrong");
    a_le16_byte_lane: assert property (le16 && req_ff.size == SZ_BYTE |-> // RL5
        ext_lane_strobe == (req_ff.addr[0] ? 4'h2 : 4'h1))
        else $error("little-endian word device byte lane wrong");
    a_le16_word_lanes: assert property (le16 && req_ff.size == SZ_WORD |-> // RL5
        ext_lane_strobe == 4'h3 && ext_wdata[15:0] == req_ff.wdata[15:0])
        else $error("little-endian word device word lanes wrong");
    a_le16_long_beats: assert property (le16 && req_ff.size == SZ_LONG && // RL6
        beat_cnt_ff == 2'h1 |-> ext_wdata[15:0] == req_ff.wdata[31:16] &&
        ext_addr[1:0] == 2'h2 && ext_lane_strobe == 4'h3)
        else $error("little-endian word device longword second half wrong");
    a_le8_word_order: assert property (le8 && req_ff.size == SZ_WORD && ext_cyc_ready && // RL7
        beat_cnt_ff == 2'h0 |-> ext_wdata[7:0] == req_ff.wdata[7:0]
        ##1 ext_wdata[7:0] == req_ff.wdata[15:8] && ext_lane_strobe == 4'h1)
        else $error("little-endian byte device word order wrong");
    a_le8_lane_zero: assert property (le8 |-> ext_lane_strobe == 4'h1) // RL7
        else $error("little-endian byte device used a lane other than zero");
    a_order_held: assert property (!srst |=> $stable(order_ff)) // RL8
        else $error("byte order changed outside reset");
    a_split_done: assert property (busy && ext_cyc_ready && beat_ff.last |=> // RL9
        rsp_valid && !ext_cyc_valid ##1 !rsp_valid)
        else $error("access did not finish after its last cycle");
    a_split_more: assert property (busy && ext_cyc_ready && !beat_ff.last |=> // RL9
        ext_cyc_valid && !rsp_valid && beat_cnt_ff == $past(beat_cnt_ff) + 2'h1)
        else $error("split access stopped early");
    a_strobe_kind: assert property (busy && req_ff.mem == MEM_DRAM |-> // RL10
        cas_ff == ext_lane_strobe && we_ff == 4'h0 && dqm_ff == 4'h0)
        else $error("column strobes do not follow the lane strobes");
    a_read_no_we: assert property (busy && !req_ff.write |-> we_ff == 4'h0) // RL10
        else $error("write strobes asserted on a read");
    // A strobe left high between cycles would look like a stray write to the memory.
    a_idle_quiet: assert property (!busy |-> ext_lane_strobe == 4'h0 && // RL10
        we_ff == 4'h0 && cas_ff == 4'h0 && dqm_ff == 4'h0)
        else $error("lane strobes asserted while no cycle runs");

    c_be8_long: cover property (be8 && req_ff.size == SZ_LONG && ext_cyc_ready && beat_ff.last);
    c_be8_word: cover property (be8 && req_ff.size == SZ_WORD && ext_cyc_ready && beat_ff.last);
    c_le16_long: cover property (le16 && req_ff.size == SZ_LONG && ext_cyc_ready && beat_ff.last);
    c_le32_byte3: cover property (le32 && req_ff.size == SZ_BYTE && req_ff.addr[1:0] == 2'h3);
    c_read_done: cover property (rsp_valid && !req_ff.write);
endmodule : ebla_aligner
`default_nettype wire

// [logic/ebla_pkg.sv]
// How it works
// RL1 - Big-endian byte device: lane zero only
// RL2 - Big-endian byte device: most significant byte first
// RL3 - Little-endian long device: byte n on lane n
// RL4 - Little-endian long device: word halves, longword all lanes
// RL5 - Little-endian word device: even low, odd high lane
// RL6 - Little-endian word device: longword low half first
// RL7 - Little-endian byte device: least significant byte first
// RL8 - Byte order caught at power-on reset, then held
// RL9 - Splitting and alignment need no software help
// RL10 - Lane strobe becomes write, column or mask strobe
`default_nettype none
package ebla_pkg;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] MEM_NORMAL = 2'h0;
    localparam logic [1:0] MEM_DRAM = 2'h1;
    localparam logic [1:0] MEM_SDRAM = 2'h2;
    localparam logic ORDER_BIG = 1'b0;
    localparam logic ORDER_LITTLE = 1'b1;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    localparam logic [3:0] NO_LANES = 4'h0;
    localparam int LANE_COUNT = 4;
    localparam int LANE_BITS = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } ebla_state_e;

    // One internal access; size and width use the SZ_ codes.
    typedef struct packed {
        logic write;
        logic [1:0] size;
        logic [1:0] width;
        logic [1:0] mem;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ebla_req_s;

    // One external cycle: lane data, lane strobes, byte offset, and for each
    // lane the byte of the internal value that it carries.
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strobe;
        logic [1:0] offset;
        logic [7:0] vbyte;
        logic last;
    } ebla_beat_s;

    // Codes above SZ_LONG count as a longword.
    function automatic logic [2:0] ebla_bytes(input logic [1:0] code);
        if (code >= SZ_LONG) begin
            return 3'h4;
        end else if (code == SZ_WORD) begin
            return 3'h2;
        end
        return 3'h1;
    endfunction : ebla_bytes
endpackage : ebla_pkg
`default_nettype wire

// [logic/ebla_lane_map.sv]
`default_nettype none
module ebla_lane_map (
    input wire logic order,
    input wire ebla_pkg::ebla_req_s req,
    input wire logic [1:0] beat,
    output ebla_pkg::ebla_beat_s map
);
    import ebla_pkg::*;

    always_comb begin
        logic [2:0] w;
        logic [2:0] s;
        logic [2:0] c;
        logic [2:0] idx;
        logic [1:0] base;
        logic [1:0] a;
        logic [1:0] lane;
        logic [1:0] v;
        w = ebla_bytes(req.width);
        s = ebla_bytes(req.size);
        c = (s < w) ? s : w;
        idx = 3'h0;
        a = 2'h0;
        lane = 2'h0;
        v = 2'h0;
        // The low address bits below the access size are ignored.
        base = req.addr[1:0] & ~(2'(s - 3'h1));
        map = '0;
        map.offset = base + 2'(beat * 2'(c)); // RL9
        map.last = (3'(beat) + 3'h1) * c >= s; // RL9
        for (int i = 0; i < LANE_COUNT; i++) begin
            if (i < int'(c)) begin
                idx = 3'(beat * 2'(c)) + 3'(i);
                a = map.offset + 2'(i);
                // Narrow devices sit on the low lanes; big-endian mirrors them.
                if (order == ORDER_LITTLE) begin
                    lane = a & 2'(w - 3'h1); // RL3 RL5
                    v = idx[1:0]; // RL6 RL7
                end else begin
                    lane = 2'(w - 3'h1) - (a & 2'(w - 3'h1)); // RL1
                    v = 2'(s - 3'h1 - idx); // RL2
                end
                map.data[lane * LANE_BITS +: LANE_BITS] = req.wdata[v * LANE_BITS +: LANE_BITS];
                map.strobe[lane] = 1'b1; // RL4
                map.vbyte[lane * 2 +: 2] = v;
            end
        end
    end
endmodule : ebla_lane_map
`default_nettype wire

// [verif/ebla_mem_model.sv]
`default_nettype none
module ebla_mem_model (
    input wire logic clk,
    input wire logic ext_cyc_valid,
    output logic ext_cyc_ready,
    input wire logic [31:0] ext_addr,
    input wire logic [31:0] ext_wdata,
    input wire logic [3:0] ext_lane_strobe,
    input wire logic [11:0] fam,
    output logic [31:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    int slow = 0;
    int n_beats = 0;
    int wait_cnt = 0;
    logic [1:0] log_off [4];
    logic [31:0] log_data [4];
    logic [3:0] log_strb [4];
    logic [11:0] log_fam [4];
    // Between cycles the lanes show the inverse of the last value, so stale data never matches.
    always @(posedge clk) begin
        logic take;
        take = ext_cyc_valid && ext_cyc_ready;
        if (take && n_beats < 4) begin
            log_off[n_beats] = ext_addr[1:0];
            log_data[n_beats] = ext_wdata;
            log_strb[n_beats] = ext_lane_strobe;
            log_fam[n_beats] = fam;
            n_beats++;
        end
        #1;
        if (take || !ext_cyc_valid) begin
            if (take) begin
                ext_rdata = ~ext_rdata;
            end
            ext_cyc_ready = 1'b0;
            wait_cnt = 0;
        end else if (wait_cnt >= slow) begin
            ext_cyc_ready = 1'b1;
            ext_rdata = {4{8'h10 + {6'h0, ext_addr[1:0]}}};
        end else begin
            wait_cnt++;
        end
    end
endmodule : ebla_mem_model
`default_nettype wire

// [verif/ebla_aligner_bench.sv]
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module ebla_aligner_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ebla_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pin = 1'b1;
    logic req_valid = 1'b0;
    ebla_req_s req = '0;
    logic req_ready, cyc_v, cyc_r, rsp_valid, order_little, ext_wr;
    logic [31:0] ext_addr, ext_wdata, ext_rdata, rsp_rdata;
    logic [3:0] strb;
    wire logic [11:0] fam;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    ebla_aligner dut_u (.clk(clk), .srst(srst), .endian_select_pin(pin),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .ext_cyc_valid(cyc_v),
        .ext_cyc_ready(cyc_r), .ext_addr(ext_addr), .ext_write(ext_wr), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .ext_lane_strobe(strb), .lane3_write_strobe(fam[11]),
        .lane2_write_strobe(fam[10]), .lane1_write_strobe(fam[9]),
        .lane0_write_strobe(fam[8]), .lane3_column_strobe(fam[7]),
        .lane2_column_strobe(fam[6]), .lane1_column_strobe(fam[5]),
        .lane0_column_strobe(fam[4]), .lane3_data_mask(fam[3]), .lane2_data_mask(fam[2]),
        .lane1_data_mask(fam[1]), .lane0_data_mask(fam[0]), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .order_little(order_little));
    ebla_mem_model mem_u (.clk(clk), .ext_cyc_valid(cyc_v), .ext_cyc_ready(cyc_r),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_lane_strobe(strb), .fam(fam),
        .ext_rdata(ext_rdata));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic rst(input logic p);
        @(posedge clk);
        #1;
        srst = 1'b1;
        pin = p;
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
    endtask : rst
    task automatic go(input logic w, input logic [1:0] sz, input logic [1:0] wd,
                      input logic [1:0] mm, input logic [31:0] a, input logic [31:0] d);
        mem_u.n_beats = 0;
        req = '{write: w, size: sz, width: wd, mem: mm, addr: a, wdata: d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        `CHK("ready", 1'b0, req_ready)
        while (rsp_valid !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        `CHK("write", w, ext_wr)
        `CHK("idle", 16'h0, {strb, fam})
    endtask : go
    // Lane data is compared only for writes; on a read the lanes still carry the request's wdata, lane-mapped.
    task automatic beat(input int i, input logic [1:0] o, input logic [3:0] s,
                        input logic [31:0] d, input logic [11:0] f, input logic cd);
        `CHK("offset", o, mem_u.log_off[i])
        `CHK("strobe", s, mem_u.log_strb[i])
        `CHK("family", f, mem_u.log_fam[i])
        if (cd) `CHK("lanes", d, mem_u.log_data[i])
    endtask : beat
    task automatic t_le32();
        rst(1'b1);
        `CHK("order", 1'b1, order_little)
        for (int o = 0; o < 4; o++) begin
            go(1'b1, SZ_BYTE, SZ_LONG, MEM_NORMAL, 32'h100 + o, 32'h5a + o);
            `CHK("beats", 1, mem_u.n_beats)
            beat(0, 2'(o), 4'h1 << o, (32'h5a + o) << (8 * o), {4'h1 << o, 8'h0}, 1'b1);
        end
        go(1'b1, SZ_WORD, SZ_LONG, MEM_SDRAM, 32'h202, 32'hbeef);
        beat(0, 2'h2, 4'hc, 32'hbeef0000, 12'h00c, 1'b1);
        go(1'b0, SZ_LONG, SZ_LONG, MEM_DRAM, 32'h300, 32'h0);
        beat(0, 2'h0, 4'hf, 32'h0, 12'h0f0, 1'b0);
        `CHK("rdata", 32'h10101010, rsp_rdata)
        go(1'b1, 2'h3, 2'h3, 2'h3, 32'h401, 32'h11223344);
        beat(0, 2'h0, 4'hf, 32'h11223344, 12'h000, 1'b1);
    endtask : t_le32
    task automatic t_le16();
        go(1'b1, SZ_BYTE, SZ_WORD, MEM_NORMAL, 32'h1, 32'hab);
        beat(0, 2'h1, 4'h2, 32'hab00, 12'h200, 1'b1);
        go(1'b1, SZ_WORD, SZ_WORD, MEM_NORMAL, 32'h2, 32'h1234);
        beat(0, 2'h2, 4'h3, 32'h1234, 12'h300, 1'b1);
        mem_u.slow = 2;
        go(1'b1, SZ_LONG, SZ_WORD, MEM_NORMAL, 32'h0, 32'h44332211);
        `CHK("beats", 2, mem_u.n_beats)
        beat(0, 2'h0, 4'h3, 32'h2211, 12'h300, 1'b1);
        beat(1, 2'h2, 4'h3, 32'h4433, 12'h300, 1'b1);
    endtask : t_le16
    task automatic t_le8();
        mem_u.slow = 1;
        go(1'b0, SZ_LONG, SZ_BYTE, MEM_SDRAM, 32'h0, 32'h0);
        `CHK("beats", 4, mem_u.n_beats)
        for (int i = 0; i < 4; i++) beat(i, 2'(i), 4'h1, 32'h0, 12'h001, 1'b0);
        `CHK("rdata", 32'h13121110, rsp_rdata)
        mem_u.slow = 0;
        go(1'b1, SZ_WORD, SZ_BYTE, MEM_NORMAL, 32'h2, 32'hbeef);
        beat(0, 2'h2, 4'h1, 32'hef, 12'h100, 1'b1);
        beat(1, 2'h3, 4'h1, 32'hbe, 12'h100, 1'b1);
    endtask : t_le8
    task automatic t_be8();
        rst(1'b0);
        pin = 1'b1;
        go(1'b1, SZ_LONG, SZ_BYTE, MEM_NORMAL, 32'h0, 32'h44332211);
        `CHK("order", 1'b0, order_little)
        for (int i = 0; i < 4; i++) beat(i, 2'(i), 4'h1, 32'h44 - 32'h11 * i, 12'h100, 1'b1);
        go(1'b0, SZ_LONG, SZ_BYTE, MEM_NORMAL, 32'h0, 32'h0);
        `CHK("rdata", 32'h10111213, rsp_rdata)
        go(1'b1, SZ_BYTE, SZ_BYTE, MEM_NORMAL, 32'h3, 32'h77);
        beat(0, 2'h3, 4'h1, 32'h77, 12'h100, 1'b1);
        go(1'b1, SZ_WORD, SZ_BYTE, MEM_NORMAL, 32'h2, 32'hbeef);
        beat(0, 2'h2, 4'h1, 32'hbe, 12'h100, 1'b1);
        beat(1, 2'h3, 4'h1, 32'hef, 12'h100, 1'b1);
    endtask : t_be8
    initial begin
        t_le32();
        t_le16();
        t_le8();
        t_be8();
        test_done();
    end
endmodule : ebla_aligner_bench
`default_nettype wire
